/* File: adc_acquire_convert_sequencer.sv */
// APB-controlled acquisition and conversion sequencer for a 10-bit SAR converter
`timescale 1ns/1ps
`default_nettype none
module adc_acquire_convert_sequencer
	import adc_seq_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Converter core
	input wire logic rc_clk_in,
	input wire logic compare_high,
	output logic sample_connect,
	output logic [9:0] trial_code,
	output logic converter_on,
	output logic [3:0] channel_select,
	output logic [5:0] port_config
);
	////////////////////////////////////////////////////////////////////////
	state_t state_q;
	logic on_q, go_q, flag_q;
	logic [3:0] chan_q, bit_idx;
	logic [5:0] port_q, div_cnt_q;
	logic [7:0] timing_q, res_hi_q, res_lo_q;
	logic [31:0] prdata_q, rd_mux;
	logic [9:0] sar_q;
	logic [4:0] tad_cnt_q;
	logic [2:0] dly_cnt_q, acq_code, clk_code;
	logic rc_meta_q, rc_sync_q, rc_prev_q;
	logic access, mapped, wr_en, tick, done, abort;
	assign acq_code = timing_q[TIM_ACQ_LSB +: 3];
	assign clk_code = timing_q[TIM_CLK_LSB +: 3];
	////////////////////////////////////////////////////////////////////////
	// APB decode, zero wait states
	assign access = psel & penable;
	assign mapped = paddr inside {OFF_MAIN, OFF_PORT, OFF_TIMING, OFF_RES_HI, OFF_RES_LO, OFF_FLAG};
	assign wr_en = access & pwrite & mapped;
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata = prdata_q;
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			OFF_MAIN: rd_mux[5:0] = {chan_q, go_q, on_q};
			OFF_PORT: rd_mux[5:0] = port_q;
			OFF_TIMING: rd_mux[7:0] = timing_q & TIMING_MASK;
			OFF_RES_HI: rd_mux[7:0] = res_hi_q;
			OFF_RES_LO: rd_mux[7:0] = res_lo_q;
			OFF_FLAG: rd_mux[FLAG_DONE_BIT] = flag_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end
	// Read data captured in the setup cycle, stable through access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (psel & ~penable & ~pwrite)
			prdata_q <= rd_mux;
	end
	////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			on_q <= 1'b0;
			chan_q <= RST_CHAN;
			port_q <= RST_PORT;
			timing_q <= RST_TIMING;
		end
		else if (wr_en)
		begin
			if (paddr == OFF_MAIN)
			begin
				on_q <= pwdata[MAIN_ON_BIT];
				chan_q <= pwdata[MAIN_CHAN_LSB +: 4];
			end
			if (paddr == OFF_PORT)
				port_q <= pwdata[5:0];
			if (paddr == OFF_TIMING)
				timing_q <= pwdata[7:0] & TIMING_MASK;
		end
	end
	// Go/done: completion clears it, a software write of 1 wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			go_q <= 1'b0;
		else if (wr_en & (paddr == OFF_MAIN))
			go_q <= pwdata[MAIN_GO_BIT];
		else if (done | ~on_q)
			go_q <= 1'b0;
	end
	// Completion flag, hardware set wins over software clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag_q <= 1'b0;
		else if (done)
			flag_q <= 1'b1;
		else if (wr_en & (paddr == OFF_FLAG))
			flag_q <= pwdata[FLAG_DONE_BIT];
	end
	// Result pair, deliberately without reset
	always_ff @(posedge pclk)
	begin
		if (done)
		begin
			if (timing_q[TIM_JUSTIFY_BIT])
			begin
				res_hi_q <= {6'h00, sar_q[9:8]};
				res_lo_q <= sar_q[7:0];
			end
			else
			begin
				res_hi_q <= sar_q[9:2];
				res_lo_q <= {sar_q[1:0], 6'h00};
			end
		end
		else if (wr_en & (paddr == OFF_RES_HI))
			res_hi_q <= pwdata[7:0];
		else if (wr_en & (paddr == OFF_RES_LO))
			res_lo_q <= pwdata[7:0];
	end
	////////////////////////////////////////////////////////////////////////
	// Bit period source
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rc_meta_q <= 1'b0;
			rc_sync_q <= 1'b0;
			rc_prev_q <= 1'b0;
		end
		else
		begin
			rc_meta_q <= rc_clk_in;
			rc_sync_q <= rc_meta_q;
			rc_prev_q <= rc_sync_q;
		end
	end
	// Divider restarts with each sequence so the first period is full
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_cnt_q <= 6'd0;
		else if ((state_q == ST_IDLE) | (state_q == ST_DELAY) | tick)
			div_cnt_q <= 6'd0;
		else
			div_cnt_q <= div_cnt_q + 6'd1;
	end
	assign tick = use_rc(clk_code) ? (rc_sync_q & ~rc_prev_q) : (div_cnt_q == tad_last(clk_code));
	////////////////////////////////////////////////////////////////////////
	// Sequencer
	assign abort = ~go_q & ((state_q == ST_DELAY) | (state_q == ST_ACQ) | (state_q == ST_CONV));
	assign done = (state_q == ST_CONV) & go_q & tick & (tad_cnt_q == CONV_TADS - 5'd1);
	assign bit_idx = 4'd9 - tad_cnt_q[3:0];
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= ST_IDLE;
			tad_cnt_q <= 5'd0;
			dly_cnt_q <= 3'd0;
			sar_q <= 10'h000;
		end
		else if (!on_q)
		begin
			state_q <= ST_IDLE;
			tad_cnt_q <= 5'd0;
		end
		else if (abort)
		begin
			state_q <= ST_HOLDOFF;
			tad_cnt_q <= 5'd0;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					tad_cnt_q <= 5'd0;
					dly_cnt_q <= 3'd0;
					sar_q <= 10'h200;
					if (go_q)
					begin
						if (use_rc(clk_code))
							state_q <= ST_DELAY;
						else if (acq_code != 3'b000)
							state_q <= ST_ACQ;
						else
							state_q <= ST_CONV;
					end
				end
				ST_DELAY:
				begin
					dly_cnt_q <= dly_cnt_q + 3'd1;
					if (dly_cnt_q == DELAY_CLKS - 3'd1)
						state_q <= (acq_code != 3'b000) ? ST_ACQ : ST_CONV;
				end
				ST_ACQ:
				begin
					if (tick)
					begin
						if (tad_cnt_q == acq_tads(acq_code) - 5'd1)
						begin
							state_q <= ST_CONV;
							tad_cnt_q <= 5'd0;
						end
						else
							tad_cnt_q <= tad_cnt_q + 5'd1;
					end
				end
				ST_CONV:
				begin
					if (tick)
					begin
						if (tad_cnt_q == CONV_TADS - 5'd1)
						begin
							state_q <= ST_HOLDOFF;
							tad_cnt_q <= 5'd0;
						end
						else
						begin
							tad_cnt_q <= tad_cnt_q + 5'd1;
							if (!compare_high)
								sar_q[bit_idx] <= 1'b0;
							if (bit_idx != 4'd0)
								sar_q[bit_idx - 4'd1] <= 1'b1;
						end
					end
				end
				ST_HOLDOFF:
				begin
					if (tick)
					begin
						if (tad_cnt_q == HOLDOFF_TADS - 5'd1)
							state_q <= ST_IDLE;
						else
							tad_cnt_q <= tad_cnt_q + 5'd1;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	// Capacitor tracks the input while the converter is on, except while converting or discharging
	assign sample_connect = on_q & (state_q inside {ST_IDLE, ST_DELAY, ST_ACQ});
	assign trial_code = sar_q;
	assign converter_on = on_q;
	assign channel_select = chan_q;
	assign port_config = port_q;
	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_conv_start;
		(state_q == ST_IDLE) && on_q && go_q && !use_rc(clk_code);
	endsequence
	property p_manual_start;
		(s_conv_start and (acq_code == 3'b000)) |=> (state_q == ST_CONV);
	endproperty
	a_manual_start: assert property (p_manual_start) else $error("manual start did not convert");
	property p_auto_start;
		(s_conv_start and (acq_code != 3'b000)) |=> (state_q == ST_ACQ);
	endproperty
	a_auto_start: assert property (p_auto_start) else $error("auto start skipped acquisition");
	property p_acq_len;
		(state_q == ST_ACQ) && on_q && go_q && tick && (tad_cnt_q == acq_tads(acq_code) - 5'd1)
			|=> (state_q == ST_CONV);
	endproperty
	a_acq_len: assert property (p_acq_len) else $error("acquisition length wrong");
	property p_done_effects;
		done |=> flag_q && !go_q && (state_q == ST_HOLDOFF);
	endproperty
	a_done_effects: assert property (p_done_effects) else $error("completion effects missing");
	property p_disconnect;
		(state_q == ST_CONV) |-> !sample_connect;
	endproperty
	a_disconnect: assert property (p_disconnect) else $error("capacitor connected in conversion");
	property p_abort_keeps;
		abort |=> $stable(res_hi_q) && $stable(res_lo_q);
	endproperty
	a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed result");
	property p_rc_delay;
		$rose(state_q == ST_DELAY) |-> (state_q == ST_DELAY)[*4] ##1 (state_q != ST_DELAY);
	endproperty
	a_rc_delay: assert property (p_rc_delay) else $error("rc delay length wrong");
	property p_holdoff_min;
		$rose(state_q == ST_HOLDOFF) && on_q |-> !(state_q == ST_IDLE)[*2];
	endproperty
	a_holdoff_min: assert property (p_holdoff_min) else $error("holdoff too short");
	property p_right_justify;
		done && timing_q[TIM_JUSTIFY_BIT] |=> (res_hi_q[7:2] == 6'h00) && (res_lo_q == $past(sar_q[7:0]));
	endproperty
	a_right_justify: assert property (p_right_justify) else $error("right justify wrong");
	property p_timing_bit6;
		(psel && !penable && !pwrite && paddr == OFF_TIMING) |=> (prdata[6] == 1'b0);
	endproperty
	a_timing_bit6: assert property (p_timing_bit6) else $error("timing bit 6 not zero");
endmodule : adc_acquire_convert_sequencer
`default_nettype wire

/* File: adc_seq_pkg.sv */
// Constants, types and decode functions for the converter sequencer
`default_nettype none
package adc_seq_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_MAIN = 8'h00;
	localparam logic [7:0] OFF_PORT = 8'h04;
	localparam logic [7:0] OFF_TIMING = 8'h08;
	localparam logic [7:0] OFF_RES_HI = 8'h0C;
	localparam logic [7:0] OFF_RES_LO = 8'h10;
	localparam logic [7:0] OFF_FLAG = 8'h14;
	// Field positions
	localparam int MAIN_ON_BIT = 0;
	localparam int MAIN_GO_BIT = 1;
	localparam int MAIN_CHAN_LSB = 2;
	localparam int FLAG_DONE_BIT = 6;
	localparam int TIM_JUSTIFY_BIT = 7;
	localparam int TIM_ACQ_LSB = 3;
	localparam int TIM_CLK_LSB = 0;
	// Values after reset
	localparam logic [3:0] RST_CHAN = 4'h0;
	localparam logic [5:0] RST_PORT = 6'h00;
	localparam logic [7:0] RST_TIMING = 8'h00;
	// Writable bits of the timing register, bit 6 is unused
	localparam logic [7:0] TIMING_MASK = 8'hBF;
	// Sequence lengths in bit periods
	localparam logic [4:0] CONV_TADS = 5'd11;
	localparam logic [4:0] HOLDOFF_TADS = 5'd2;
	// Instruction cycle delay ahead of the RC clock
	localparam int CLK_PERIOD_NS = 25;
	localparam int INSTR_CYCLE_NS = 100;
	localparam logic [2:0] DELAY_CLKS = 3'((INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DELAY = 3'b001,
		ST_ACQ = 3'b010,
		ST_CONV = 3'b011,
		ST_HOLDOFF = 3'b100
	} state_t;

	// Acquisition length in bit periods
	function automatic logic [4:0] acq_tads(input logic [2:0] code);
		case (code)
			3'b111: acq_tads = 5'd20;
			3'b110: acq_tads = 5'd16;
			3'b101: acq_tads = 5'd12;
			3'b100: acq_tads = 5'd8;
			3'b011: acq_tads = 5'd6;
			3'b010: acq_tads = 5'd4;
			3'b001: acq_tads = 5'd2;
			default: acq_tads = 5'd0;
		endcase
	endfunction : acq_tads

	// Last divider count of one bit period
	function automatic logic [5:0] tad_last(input logic [2:0] code);
		case (code)
			3'b000: tad_last = 6'd1;
			3'b001: tad_last = 6'd7;
			3'b010: tad_last = 6'd31;
			3'b100: tad_last = 6'd3;
			3'b101: tad_last = 6'd15;
			3'b110: tad_last = 6'd63;
			default: tad_last = 6'd1;
		endcase
	endfunction : tad_last

	function automatic logic use_rc(input logic [2:0] code);
		use_rc = (code[1:0] == 2'b11);
	endfunction : use_rc
endpackage : adc_seq_pkg
`default_nettype wire

/* File: adc_core_model.sv */
// Behavioural converter core: held sample, comparator and RC oscillator
`timescale 1ns/1ps
`default_nettype none
module adc_core_model
(
	// Core side
	input wire logic pclk,
	input wire logic sample_connect,
	input wire logic [9:0] trial_code,
	input wire logic [9:0] level,
	output logic compare_high,
	output logic rc_clk
);
	logic [9:0] held_q;
	// Tracks the input only while connected, frozen once conversion starts
	always_ff @(posedge pclk)
	begin
		if (sample_connect)
			held_q <= level;
	end
	assign compare_high = held_q >= trial_code;
	// Free running, period unrelated to pclk
	initial rc_clk = 1'b0;
	always #65.3 rc_clk = ~rc_clk;
endmodule : adc_core_model
`default_nettype wire

/* File: adc_acquire_convert_sequencer_tb.sv */
// Self-checking bench for the converter sequencer over APB
`timescale 1ns/1ps
`default_nettype none
module adc_acquire_convert_sequencer_tb
	import adc_seq_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, hi_e, lo_e;
	logic pready, pslverr, err, rc_clk, compare_high, sample_connect, sc_q, converter_on;
	logic [9:0] trial_code;
	logic [9:0] level = 10'h000;
	logic [3:0] channel_select;
	logic [5:0] port_config;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	int t_go, t_fall, t_rise;
	int dv[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
	int aq[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

	adc_acquire_convert_sequencer dut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rc_clk_in(rc_clk), .compare_high(compare_high), .sample_connect(sample_connect),
		.trial_code(trial_code), .converter_on(converter_on), .channel_select(channel_select),
		.port_config(port_config)
	);
	adc_core_model core
	(
		.pclk(pclk), .sample_connect(sample_connect), .trial_code(trial_code),
		.level(level), .compare_high(compare_high), .rc_clk(rc_clk)
	);

	always #12.5 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	// Sampled mid-cycle so edges of the combinational output never race
	always @(negedge pclk)
	begin
		sc_q <= sample_connect;
		if (sc_q === 1'b1 && sample_connect === 1'b0)
			t_fall = cyc;
		if (sc_q === 1'b0 && sample_connect === 1'b1)
			t_rise = cyc;
	end

	////////////////////////////////////////
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rng(input int v, input int lo, input int hi);
		comparisons++;
		if (v < lo || v > hi)
		begin
			error_cnt++;
			$display("BAD %0t span %0d outside %0d..%0d", $time, v, lo, hi);
		end
	endtask : rng

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk

	task automatic reconnect;
		int n;
		n = 0;
		while (sample_connect !== 1'b1 && n < 400)
		begin
			@(negedge pclk);
			n++;
		end
		@(negedge pclk);
		chk(32'(sample_connect), 32'h1);
	endtask : reconnect

	// One conversion with clock and acquisition code both equal to i
	task automatic conv(input int i);
		int n;
		logic [9:0] v;
		v = 10'h2A5 + 10'(i * 199);
		level <= v;
		apb(1'b1, OFF_TIMING, {24'h0, i[0], 1'b0, 3'(i), 3'(i)});
		apb(1'b1, OFF_MAIN, 32'h17);
		t_go = cyc;
		rdchk(OFF_MAIN, 32'h17);
		n = 0;
		do
		begin
			apb(1'b0, OFF_MAIN, 32'h0);
			n++;
		end
		while (rd[MAIN_GO_BIT] !== 1'b0 && n < 2000);
		hi_e = i[0] ? {30'h0, v[9:8]} : {24'h0, v[9:2]};
		lo_e = i[0] ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00};
		chk(rd, 32'h15);
		rdchk(OFF_RES_HI, hi_e);
		rdchk(OFF_RES_LO, lo_e);
		rdchk(OFF_FLAG, 32'h40);
		apb(1'b1, OFF_FLAG, 32'h0);
		reconnect();
		if (dv[i] > 0)
		begin
			rng(t_fall - t_go, aq[i] * dv[i], (aq[i] + 1) * dv[i] + 2);
			rng(t_rise - t_fall, 13 * dv[i] - 1, 13 * dv[i] + 2);
		end
		else
			rng(t_fall - t_go, DELAY_CLKS, 4000);
	endtask : conv

	task conclude;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(OFF_TIMING, 32'h0);
		rdchk(OFF_MAIN, 32'h0);
		apb(1'b1, OFF_TIMING, 32'hFFFFFFFF);
		rdchk(OFF_TIMING, 32'hBF);
		apb(1'b1, OFF_PORT, 32'hFFFFFFFF);
		rdchk(OFF_PORT, 32'h3F);
		chk(32'(port_config), 32'h3F);
		rdchk(8'h18, 32'h0);
		chk(32'(err), 32'h1);
		apb(1'b1, OFF_MAIN, 32'h15);
		@(negedge pclk);
		chk(32'(channel_select), 32'h5);
		chk(32'(converter_on), 32'h1);
		for (int i = 0; i < 8; i++)
			conv(i);
		// Abort mid-conversion: old result must survive
		apb(1'b1, OFF_TIMING, 32'h02);
		level <= 10'h0F0;
		apb(1'b1, OFF_MAIN, 32'h17);
		rdchk(OFF_MAIN, 32'h17);
		apb(1'b1, OFF_MAIN, 32'h15);
		rdchk(OFF_MAIN, 32'h15);
		rdchk(OFF_RES_HI, hi_e);
		rdchk(OFF_RES_LO, lo_e);
		rdchk(OFF_FLAG, 32'h0);
		reconnect();
		// Reset during a running conversion
		apb(1'b1, OFF_MAIN, 32'h17);
		rdchk(OFF_MAIN, 32'h17);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(32'(converter_on), 32'h0);
		presetn <= 1'b1;
		rdchk(OFF_MAIN, 32'h0);
		rdchk(OFF_TIMING, 32'h0);
		rdchk(OFF_RES_HI, hi_e);
		rdchk(OFF_RES_LO, lo_e);
		rdchk(OFF_FLAG, 32'h0);
		chk(32'(sample_connect), 32'h0);
		conclude();
	end

	// Whole run needs well under 15000 cycles
	initial
	begin
		repeat (40000) @(posedge pclk);
		error_cnt++;
		conclude();
	end
endmodule : adc_acquire_convert_sequencer_tb
`default_nettype wire
